// [common/lpoc_pkg.sv]
package lpoc_pkg;

  // ==========================================================================
  // Value types. Percent values are signed hundredths of a percent.
  typedef logic signed [15:0] lpoc_pct_t;
  typedef logic [15:0] lpoc_rate_t;

  typedef struct packed {
    lpoc_pct_t hi;
    lpoc_pct_t lo;
  } lpoc_lim_s;

  typedef enum {
    LPOC_MODE_AUTO,
    LPOC_MODE_MANUAL,
    LPOC_MODE_TRACK,
    LPOC_MODE_SBRK
  } lpoc_mode_e;

  // ==========================================================================
  // Scale and timing.
  localparam lpoc_pct_t FULL_SCALE = 16'sh2710;
  localparam int CLK_MHZ = 200;
  localparam int TICK_MS = 110;
  localparam int TICK_CYCLES = TICK_MS * CLK_MHZ * 1000;
  localparam int HOLD_MS = 2000;
  localparam int HOLD_TICKS = HOLD_MS / TICK_MS;
  localparam int MS_PER_S = 1000;

  // ==========================================================================
  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TRACK = 8'h04;
  localparam logic [7:0] OFS_OUT_HI = 8'h08;
  localparam logic [7:0] OFS_OUT_LO = 8'h0C;
  localparam logic [7:0] OFS_SCHED_HI = 8'h10;
  localparam logic [7:0] OFS_SCHED_LO = 8'h14;
  localparam logic [7:0] OFS_RATE = 8'h18;
  localparam logic [7:0] OFS_SBRK_OP = 8'h1C;
  localparam logic [7:0] OFS_FORCED = 8'h20;
  localparam logic [7:0] OFS_TRIM = 8'h24;
  localparam logic [7:0] OFS_TUNE_HI = 8'h28;
  localparam logic [7:0] OFS_TUNE_LO = 8'h2C;
  localparam logic [7:0] OFS_MANUAL = 8'h30;
  localparam logic [7:0] OFS_WORK_HI = 8'h34;
  localparam logic [7:0] OFS_WORK_LO = 8'h38;
  localparam logic [7:0] OFS_WORKING_OUTPUT = 8'h3C;
  localparam logic [7:0] OFS_TARGET = 8'h40;
  localparam logic [7:0] OFS_FEEDFORWARD_VALUE = 8'h44;
  localparam logic [7:0] OFS_STATUS = 8'h48;

  // ==========================================================================
  // Control bit positions.
  localparam int CTRL_TRACK = 0;
  localparam int CTRL_SBRK_HOLD = 1;
  localparam int CTRL_FORCED = 2;
  localparam int CTRL_SCHED_OVR = 3;
  localparam int CTRL_MANUAL = 4;
  localparam int CTRL_FORCED_TRK = 5;
  localparam int CTRL_BITS = 6;

  // ==========================================================================
  // Reset values.
  localparam logic [CTRL_BITS-1:0] RST_CTRL = 6'h00;
  localparam lpoc_pct_t RST_ZERO = 16'sh0000;
  localparam lpoc_rate_t RST_RATE = 16'h0000;

endpackage : lpoc_pkg

// [logic/lpoc_top.sv]
`timescale 1ns/10ps
// Contract
// - Track enabled drives output to the track value, range -100 to 100%.
// - While tracking the PID stays automatic and follows the output.
// - Leaving tracking resumes control bumplessly from the tracked value.
// - Unconnected remote limits start at plus and minus full scale.
// - Schedule override limits replace the active gain-set limits.
// - Tighter of remote and scheduled limits, then clamp by overall.
// - Working high and low limits are readable, not writable.
// - Tuning adds tune limits; overall limits still take precedence.
// - Rate limit steps working output toward target until equal.
// - Step comes from rate and 110 ms; small remainder applies at once.
// - Direction and size are recomputed on every execution.
// - Steps below output resolution accumulate until they take effect.
// - Rate limiting stays active in manual mode.
// - Sensor break selects preset or hold by configured mode.
// - Preset mode steps without rate limit, else ramps at the rate.
// - Hold keeps last good output; with rate, the 2 s old value.
// - Leaving sensor break ramps from preset to control bumplessly.
// - Default auto to manual transfer keeps present output power.
// - Forced step mode loads the forced value on transfer to manual.
// - With forced tracking, manual edits copy back to the forced value.
// - PID contribution clamped to plus and minus feedforward trim limit.
// - Feedforward plus trimmed PID becomes the PID output.
module lpoc_top
  import lpoc_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // Register port
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rd_data_out,
  // PID algorithm and measurement side
  input wire lpoc_pct_t pid_demand_in,
  input wire lpoc_pct_t feedforward_value_in,
  input wire lpoc_lim_s pid_set_limits_in,
  input wire logic tuning_in,
  input wire logic sensor_break_in,
  input wire lpoc_lim_s remote_limits_in,
  input wire logic remote_connected_in,
  // Output driver and PID feedback
  output lpoc_pct_t working_output_out,
  output lpoc_lim_s working_limits_out,
  output lpoc_pct_t pid_feedback_out,
  output logic pid_auto_out,
  output logic pid_track_out,
  output logic tick_out
);

  // ==========================================================================
  // Helpers.
  function automatic lpoc_pct_t clamp(input logic signed [17:0] v,
                                      input lpoc_pct_t lo,
                                      input lpoc_pct_t hi);
    if (v > 18'(hi)) begin
      return hi;
    end else if (v < 18'(lo)) begin
      return lo;
    end
    return lpoc_pct_t'(v);
  endfunction : clamp

  function automatic lpoc_pct_t min_pct(input lpoc_pct_t a,
                                        input lpoc_pct_t b);
    return (a < b) ? a : b;
  endfunction : min_pct

  function automatic lpoc_pct_t max_pct(input lpoc_pct_t a,
                                        input lpoc_pct_t b);
    return (a > b) ? a : b;
  endfunction : max_pct

  // ==========================================================================
  // Storage.
  logic [CTRL_BITS-1:0] ctrl;
  lpoc_pct_t track_value;
  lpoc_pct_t overall_high_limit;
  lpoc_pct_t overall_low_limit;
  lpoc_pct_t schedule_override_high;
  lpoc_pct_t schedule_override_low;
  lpoc_rate_t rate_limit;
  lpoc_pct_t sensor_break_preset;
  lpoc_pct_t forced_manual_value;
  lpoc_pct_t feedforward_trim_limit;
  lpoc_pct_t tune_high_limit;
  lpoc_pct_t tune_low_limit;
  lpoc_pct_t manual_value;
  lpoc_pct_t remote_high_limit;
  lpoc_pct_t remote_low_limit;
  lpoc_pct_t target_output;
  lpoc_pct_t feedforward_out;
  lpoc_pct_t hold_value;
  lpoc_mode_e mode;
  logic [31:0] step_acc;
  logic sbrk_seen;
  logic manual_prev;
  logic [24:0] tick_cnt;
  logic tick;
  lpoc_pct_t hist [HOLD_TICKS];

  lpoc_pct_t next_trim;
  lpoc_pct_t next_ff;
  lpoc_pct_t next_hold_src;
  lpoc_pct_t next_demand;
  lpoc_pct_t next_target;
  lpoc_pct_t next_work;
  lpoc_lim_s next_sched;
  lpoc_lim_s next_tight;
  lpoc_lim_s next_lim;
  lpoc_mode_e next_mode;
  logic [31:0] next_acc;
  logic [31:0] next_step;
  logic signed [17:0] next_diff;
  logic [31:0] next_mag;

  // ==========================================================================
  // Algorithm tick divider.
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else if (tick_cnt == 25'(TICK_LEN - 1)) begin
      tick_cnt <= '0;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 25'd1;
      tick <= 1'b0;
    end
  end

  // ==========================================================================
  // Configuration writes.
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      ctrl <= RST_CTRL;
      track_value <= RST_ZERO;
      overall_high_limit <= FULL_SCALE;
      overall_low_limit <= -FULL_SCALE;
      schedule_override_high <= FULL_SCALE;
      schedule_override_low <= -FULL_SCALE;
      rate_limit <= RST_RATE;
      sensor_break_preset <= RST_ZERO;
      feedforward_trim_limit <= FULL_SCALE;
      tune_high_limit <= FULL_SCALE;
      tune_low_limit <= -FULL_SCALE;
    end else if (wr_in) begin
      case (addr_in)
        OFS_CTRL: ctrl <= wr_data_in[CTRL_BITS-1:0];
        OFS_TRACK: track_value <= wr_data_in[15:0];
        OFS_OUT_HI: overall_high_limit <= wr_data_in[15:0];
        OFS_OUT_LO: overall_low_limit <= wr_data_in[15:0];
        OFS_SCHED_HI: schedule_override_high <= wr_data_in[15:0];
        OFS_SCHED_LO: schedule_override_low <= wr_data_in[15:0];
        OFS_RATE: rate_limit <= wr_data_in[15:0];
        OFS_SBRK_OP: sensor_break_preset <= wr_data_in[15:0];
        OFS_TRIM: feedforward_trim_limit <= wr_data_in[15:0];
        OFS_TUNE_HI: tune_high_limit <= wr_data_in[15:0];
        OFS_TUNE_LO: tune_low_limit <= wr_data_in[15:0];
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // Manual value and forced value. The transfer load beats a software
  // write in the same cycle so the operator never loses the bumpless start.
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      manual_prev <= 1'b0;
      manual_value <= RST_ZERO;
      forced_manual_value <= RST_ZERO;
    end else begin
      manual_prev <= ctrl[CTRL_MANUAL];
      if (ctrl[CTRL_MANUAL] && !manual_prev) begin
        if (ctrl[CTRL_FORCED]) begin
          manual_value <= forced_manual_value;
        end else begin
          manual_value <= working_output_out;
        end
      end else if (wr_in && addr_in == OFS_MANUAL) begin
        manual_value <= wr_data_in[15:0];
        if (ctrl[CTRL_FORCED] && ctrl[CTRL_FORCED_TRK]) begin
          forced_manual_value <= wr_data_in[15:0];
        end
      end else if (wr_in && addr_in == OFS_FORCED) begin
        forced_manual_value <= wr_data_in[15:0];
      end
    end
  end

  // ==========================================================================
  // Per-tick computation: limits, demand, then rate limit.
  always_comb begin
    next_trim = clamp(18'(pid_demand_in), -feedforward_trim_limit,
                      feedforward_trim_limit);
    next_ff = clamp(18'(feedforward_value_in) + 18'(next_trim),
                    -FULL_SCALE, FULL_SCALE);

    if (ctrl[CTRL_SCHED_OVR]) begin
      next_sched.hi = schedule_override_high;
      next_sched.lo = schedule_override_low;
    end else begin
      next_sched = pid_set_limits_in;
    end
    next_tight.hi = min_pct(remote_high_limit, next_sched.hi);
    next_tight.lo = max_pct(remote_low_limit, next_sched.lo);
    if (tuning_in) begin
      next_tight.hi = min_pct(next_tight.hi, tune_high_limit);
      next_tight.lo = max_pct(next_tight.lo, tune_low_limit);
    end
    // Overall limits are applied last so they always win.
    next_lim.hi = min_pct(next_tight.hi, overall_high_limit);
    next_lim.lo = max_pct(next_tight.lo, overall_low_limit);

    if (ctrl[CTRL_TRACK]) begin
      next_mode = LPOC_MODE_TRACK;
    end else if (sensor_break_in) begin
      next_mode = LPOC_MODE_SBRK;
    end else if (ctrl[CTRL_MANUAL]) begin
      next_mode = LPOC_MODE_MANUAL;
    end else begin
      next_mode = LPOC_MODE_AUTO;
    end

    if (sbrk_seen) begin
      next_hold_src = hold_value;
    end else if (rate_limit != RST_RATE) begin
      next_hold_src = hist[HOLD_TICKS-1];
    end else begin
      next_hold_src = working_output_out;
    end

    case (next_mode)
      LPOC_MODE_TRACK: next_demand = track_value;
      LPOC_MODE_SBRK: begin
        if (ctrl[CTRL_SBRK_HOLD]) begin
          next_demand = next_hold_src;
        end else begin
          next_demand = sensor_break_preset;
        end
      end
      LPOC_MODE_MANUAL: next_demand = manual_value;
      default: next_demand = next_ff;
    endcase
    next_target = clamp(18'(next_demand), next_lim.lo, next_lim.hi);

    // Direction and size are rebuilt from scratch every tick, so a new rate
    // or target acts at once. Sub-resolution steps carry in the accumulator.
    next_diff = 18'(next_target) - 18'(working_output_out);
    next_mag = (next_diff < 0) ? 32'(-next_diff) : 32'(next_diff);
    next_acc = step_acc + 32'(rate_limit) * 32'(TICK_MS);
    next_step = next_acc / 32'(MS_PER_S);
    if (next_mode == LPOC_MODE_TRACK || rate_limit == RST_RATE) begin
      next_work = next_target;
      next_acc = '0;
    end else if (next_mag <= next_step) begin
      next_work = next_target;
      next_acc = '0;
    end else if (next_diff > 0) begin
      next_work = lpoc_pct_t'(18'(working_output_out) + 18'(next_step));
      next_acc = next_acc - next_step * 32'(MS_PER_S);
    end else begin
      next_work = lpoc_pct_t'(18'(working_output_out) - 18'(next_step));
      next_acc = next_acc - next_step * 32'(MS_PER_S);
    end
  end

  // ==========================================================================
  // Tick registers. Rate limiting runs in every mode but track, including
  // manual and the ramp out of sensor break back to control.
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      remote_high_limit <= FULL_SCALE;
      remote_low_limit <= -FULL_SCALE;
      working_output_out <= RST_ZERO;
      working_limits_out.hi <= FULL_SCALE;
      working_limits_out.lo <= -FULL_SCALE;
      target_output <= RST_ZERO;
      feedforward_out <= RST_ZERO;
      step_acc <= '0;
      mode <= LPOC_MODE_AUTO;
    end else if (tick) begin
      if (remote_connected_in) begin
        remote_high_limit <= remote_limits_in.hi;
        remote_low_limit <= remote_limits_in.lo;
      end
      working_limits_out <= next_lim;
      target_output <= next_target;
      feedforward_out <= next_ff;
      working_output_out <= next_work;
      step_acc <= next_acc;
      mode <= next_mode;
    end
  end

  // ==========================================================================
  // Sensor-break hold capture and output history.
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      sbrk_seen <= 1'b0;
      hold_value <= RST_ZERO;
    end else if (tick) begin
      sbrk_seen <= sensor_break_in;
      if (sensor_break_in && !sbrk_seen) begin
        hold_value <= next_hold_src;
      end
    end
  end

  generate
    for (genvar i = 0; i < HOLD_TICKS; i++) begin : g_hist
      always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
          hist[i] <= RST_ZERO;
        end else if (tick) begin
          if (i == 0) begin
            hist[i] <= working_output_out;
          end else begin
            hist[i] <= hist[(i == 0) ? 0 : i - 1];
          end
        end
      end
    end
  endgenerate

  // ==========================================================================
  // PID side. The PID stays automatic while tracking and is fed back the
  // output with the feedforward share removed.
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      pid_auto_out <= 1'b1;
      pid_track_out <= 1'b0;
      pid_feedback_out <= RST_ZERO;
      tick_out <= 1'b0;
    end else begin
      tick_out <= tick;
      if (tick) begin
        pid_auto_out <= (next_mode != LPOC_MODE_MANUAL);
        pid_track_out <= (next_mode == LPOC_MODE_TRACK);
        pid_feedback_out <= clamp(18'(next_work) -
                                  18'(feedforward_value_in),
                                  -FULL_SCALE, FULL_SCALE);
      end
    end
  end

  // ==========================================================================
  // Register reads, answered in the following cycle.
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      rd_data_out <= '0;
    end else if (rd_in) begin
      case (addr_in)
        OFS_CTRL: rd_data_out <= 32'(ctrl);
        OFS_TRACK: rd_data_out <= {16'h0000, track_value};
        OFS_OUT_HI: rd_data_out <= {16'h0000, overall_high_limit};
        OFS_OUT_LO: rd_data_out <= {16'h0000, overall_low_limit};
        OFS_SCHED_HI: rd_data_out <= {16'h0000, schedule_override_high};
        OFS_SCHED_LO: rd_data_out <= {16'h0000, schedule_override_low};
        OFS_RATE: rd_data_out <= {16'h0000, rate_limit};
        OFS_SBRK_OP: rd_data_out <= {16'h0000, sensor_break_preset};
        OFS_FORCED: rd_data_out <= {16'h0000, forced_manual_value};
        OFS_TRIM: rd_data_out <= {16'h0000, feedforward_trim_limit};
        OFS_TUNE_HI: rd_data_out <= {16'h0000, tune_high_limit};
        OFS_TUNE_LO: rd_data_out <= {16'h0000, tune_low_limit};
        OFS_MANUAL: rd_data_out <= {16'h0000, manual_value};
        OFS_WORK_HI: rd_data_out <= {16'h0000, working_limits_out.hi};
        OFS_WORK_LO: rd_data_out <= {16'h0000, working_limits_out.lo};
        OFS_WORKING_OUTPUT: rd_data_out <= {16'h0000, working_output_out};
        OFS_TARGET: rd_data_out <= {16'h0000, target_output};
        OFS_FEEDFORWARD_VALUE: rd_data_out <= {16'h0000, feedforward_out};
        OFS_STATUS: rd_data_out <= {28'h0000000, sbrk_seen,
                                    mode == LPOC_MODE_SBRK,
                                    mode == LPOC_MODE_MANUAL,
                                    mode == LPOC_MODE_TRACK};
        default: rd_data_out <= '0;
      endcase
    end
  end

endmodule : lpoc_top

// [test/lpoc_top_properties.sv]
`timescale 1ns/10ps
module lpoc_top_properties
  import lpoc_pkg::*;
#(
  parameter int TICK_LEN = 20
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // Watched ports
  input wire logic rd_in,
  input wire logic [31:0] rd_data_out,
  input wire lpoc_pct_t feedforward_value_in,
  input wire lpoc_pct_t working_output_out,
  input wire lpoc_lim_s working_limits_out,
  input wire lpoc_pct_t pid_feedback_out,
  input wire logic pid_auto_out,
  input wire logic pid_track_out,
  input wire logic tick_out
);

  // ====================
  // Tick spacing.
  logic [31:0] gap;
  logic seen;

  // The first tick only arms the check, as its distance to reset is free.
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      gap <= 32'h00000000;
      seen <= 1'b0;
    end else if (tick_out) begin
      gap <= 32'h00000000;
      seen <= 1'b1;
    end else begin
      gap <= gap + 32'h00000001;
    end
  end

  // ====================
  // Properties.
  default clocking @(posedge mclk_in); endclocking
  default disable iff (reset_in);

  a_tick_gap: assert property (tick_out && seen |->
    gap == TICK_LEN - 1)
    else $error("Tick spacing differs from the tick length.");
  a_tick_pulse: assert property (tick_out |=> !tick_out)
    else $error("Tick pulse is longer than one cycle.");
  a_out_hold: assert property (!tick_out |->
    $stable(working_output_out))
    else $error("Working output moved between ticks.");
  a_lim_hold: assert property (!tick_out |->
    $stable(working_limits_out))
    else $error("Working limits moved between ticks.");
  a_mode_hold: assert property (!tick_out |->
    $stable({pid_auto_out, pid_track_out}))
    else $error("Mode outputs moved between ticks.");
  a_track_auto: assert property (pid_track_out |-> pid_auto_out)
    else $error("Tracking without automatic mode.");
  a_out_in_lim: assert property (tick_out |->
    working_output_out <= working_limits_out.hi &&
    working_output_out >= working_limits_out.lo)
    else $error("Working output outside the working limits.");
  a_lim_order: assert property (
    working_limits_out.lo <= working_limits_out.hi)
    else $error("Working low limit above high limit.");
  a_fb_follow: assert property (tick_out &&
    $stable(feedforward_value_in) |->
    pid_feedback_out == working_output_out - feedforward_value_in)
    else $error("Feedback is not output minus feedforward.");
  a_rd_upper: assert property (rd_in |=>
    rd_data_out[31:16] == 16'h0000)
    else $error("Read data upper half not zero.");

  c_track: cover property (tick_out && pid_track_out);
  c_manual: cover property (tick_out && !pid_auto_out);
  c_read: cover property (rd_in ##1 rd_data_out != 32'h00000000);

endmodule : lpoc_top_properties

// [test/lpoc_pid.sv]
`timescale 1ns/10ps
module lpoc_pid
  import lpoc_pkg::*;
(
  // Clock
  input wire logic mclk_in,
  // Drive toward the conditioner
  output lpoc_pct_t pid_demand_out,
  output lpoc_pct_t feedforward_out,
  output lpoc_lim_s set_limits_out,
  output logic tuning_out,
  output logic sensor_break_out,
  output lpoc_lim_s remote_limits_out,
  output logic remote_connected_out
);

  // ====================
  // Values set by the bench, shown just after the next edge.
  lpoc_pct_t dem = 16'sh0000;
  lpoc_pct_t ff = 16'sh0000;
  lpoc_lim_s lim = {FULL_SCALE, -FULL_SCALE};
  lpoc_lim_s rem = {FULL_SCALE, -FULL_SCALE};
  logic tune = 1'b0;
  logic sb = 1'b0;
  logic con = 1'b0;

  initial {pid_demand_out, feedforward_out, set_limits_out, tuning_out,
    sensor_break_out, remote_limits_out, remote_connected_out} = '0;

  always @(posedge mclk_in) begin
    pid_demand_out <= dem;
    feedforward_out <= ff;
    set_limits_out <= lim;
    tuning_out <= tune;
    sensor_break_out <= sb;
    remote_connected_out <= con;
    // An unwired remote source floats, so it toggles and must be ignored.
    if (con) begin
      remote_limits_out <= rem;
    end else begin
      remote_limits_out <= ~remote_limits_out;
    end
  end

endmodule : lpoc_pid

// [test/lpoc_top_tb.sv]
`timescale 1ns/10ps
module lpoc_top_tb
  import lpoc_pkg::*;
;

  // ====================
  // Signals.
  localparam int TL = 20;
  logic mclk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [7:0] addr_in = 8'h00;
  logic [31:0] wr_data_in = 32'h00000000;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [31:0] rd_data_out;
  lpoc_pct_t pid_demand_in, feedforward_value_in;
  lpoc_pct_t working_output_out, pid_feedback_out;
  lpoc_lim_s pid_set_limits_in, remote_limits_in, working_limits_out;
  logic tuning_in, sensor_break_in, remote_connected_in;
  logic pid_auto_out, pid_track_out, tick_out;
  int fails = 0;
  int n_checks = 0;
  int ex;
  logic [31:0] rv;

  always #2.5 mclk_in = ~mclk_in;

  lpoc_top #(.TICK_LEN(TL)) i_lpoc_top (.mclk_in(mclk_in),
    .reset_in(reset_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
    .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
    .pid_demand_in(pid_demand_in),
    .feedforward_value_in(feedforward_value_in),
    .pid_set_limits_in(pid_set_limits_in), .tuning_in(tuning_in),
    .sensor_break_in(sensor_break_in), .remote_limits_in(remote_limits_in),
    .remote_connected_in(remote_connected_in),
    .working_output_out(working_output_out),
    .working_limits_out(working_limits_out),
    .pid_feedback_out(pid_feedback_out), .pid_auto_out(pid_auto_out),
    .pid_track_out(pid_track_out), .tick_out(tick_out));

  lpoc_pid i_lpoc_pid (.mclk_in(mclk_in), .pid_demand_out(pid_demand_in),
    .feedforward_out(feedforward_value_in),
    .set_limits_out(pid_set_limits_in), .tuning_out(tuning_in),
    .sensor_break_out(sensor_break_in), .remote_limits_out(remote_limits_in),
    .remote_connected_out(remote_connected_in));

  // ====================
  // Tasks.
  task automatic chk(input string n, input logic [15:0] got,
                     input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", n, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk_in);
    addr_in <= a;
    wr_data_in <= {16'h0000, d};
    wr_in <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1 rv = rd_data_out;
  endtask : rd

  // Returns just after the edge on which the tick's outputs appear.
  task automatic tk();
    int i;
    i = 0;
    do begin
      @(posedge mclk_in);
      #1 i++;
    end while (tick_out !== 1'b1 && i < 3 * TL);
    if (i >= 3 * TL) fails++;
  endtask : tk

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test

  // About 60 ticks of 20 cycles are needed; three times that is ample.
  initial begin
    #20000;
    fails++;
    finish_test();
  end

  // ====================
  // Sequence.
  initial begin
    repeat (20) @(posedge mclk_in);
    reset_in <= 1'b0;
    @(posedge mclk_in);
    #1 chk("working_output", working_output_out, 16'h0000);
    wr(OFS_WORK_HI, 16'h0000);
    rd(OFS_WORK_HI);
    chk("work_hi", rv[15:0], 16'h2710);
    rd(OFS_WORK_LO);
    chk("work_lo", rv[15:0], 16'hD8F0);
    rd(8'hFC);
    chk("unmapped", rv[15:0], 16'h0000);
    wr(OFS_RATE, 16'h03E8);
    i_lpoc_pid.dem <= 16'sh03E8;
    ex = 0;
    for (int k = 0; k < 6; k++) begin
      if (k == 2) wr(OFS_RATE, 16'h07D0);
      tk();
      ex = ex + ((k < 2) ? 110 : 220);
      if (ex > 1000) ex = 1000;
      chk("ramp", working_output_out, ex[15:0]);
    end
    wr(OFS_RATE, 16'h0001);
    i_lpoc_pid.dem <= 16'sh03E9;
    for (int k = 1; k <= 10; k++) begin
      tk();
      chk("fine", working_output_out, 16'h03E8 + (k == 10));
    end
    wr(OFS_RATE, 16'h03E8);
    wr(OFS_CTRL, 16'h0010);
    i_lpoc_pid.dem <= 16'sh0000;
    tk();
    chk("man_keep", working_output_out, 16'h03E9);
    chk("man_auto", {15'h0000, pid_auto_out}, 16'h0000);
    wr(OFS_MANUAL, 16'h0000);
    tk();
    chk("man_ramp", working_output_out, 16'h037B);
    wr(OFS_CTRL, 16'h0000);
    wr(OFS_RATE, 16'h0000);
    wr(OFS_FORCED, 16'h02BC);
    tk();
    wr(OFS_CTRL, 16'h0034);
    tk();
    chk("forced", working_output_out, 16'h02BC);
    wr(OFS_MANUAL, 16'h0100);
    tk();
    chk("man_edit", working_output_out, 16'h0100);
    rd(OFS_FORCED);
    chk("forced_copy", rv[15:0], 16'h0100);
    wr(OFS_CTRL, 16'h0001);
    wr(OFS_TRACK, 16'h05DC);
    tk();
    chk("track", working_output_out, 16'h05DC);
    chk("track_mode", 16'({pid_auto_out, pid_track_out}), 16'h0003);
    chk("track_fb", pid_feedback_out, 16'h05DC);
    rd(OFS_STATUS);
    chk("status", rv[15:0], 16'h0001);
    i_lpoc_pid.dem <= 16'sh05DC;
    wr(OFS_CTRL, 16'h0000);
    tk();
    chk("untrack", working_output_out, 16'h05DC);
    wr(OFS_SBRK_OP, 16'hFE0C);
    i_lpoc_pid.sb <= 1'b1;
    tk();
    chk("sb_preset", working_output_out, 16'hFE0C);
    wr(OFS_RATE, 16'h03E8);
    i_lpoc_pid.sb <= 1'b0;
    tk();
    chk("sb_exit", working_output_out, 16'hFE7A);
    wr(OFS_RATE, 16'h0000);
    wr(OFS_CTRL, 16'h0002);
    i_lpoc_pid.sb <= 1'b1;
    i_lpoc_pid.dem <= 16'sh0000;
    tk();
    chk("sb_hold", working_output_out, 16'hFE7A);
    i_lpoc_pid.sb <= 1'b0;
    wr(OFS_CTRL, 16'h0000);
    wr(OFS_TRIM, 16'h00C8);
    i_lpoc_pid.ff <= 16'sh03E8;
    i_lpoc_pid.dem <= 16'sh1388;
    tk();
    chk("ff_trim", working_output_out, 16'h04B0);
    rd(OFS_FEEDFORWARD_VALUE);
    chk("feedforward_value", rv[15:0], 16'h04B0);
    wr(OFS_TUNE_HI, 16'h0400);
    wr(OFS_TUNE_LO, 16'hF000);
    i_lpoc_pid.tune <= 1'b1;
    tk();
    chk("tune", working_output_out, 16'h0400);
    wr(OFS_OUT_HI, 16'h0300);
    tk();
    chk("tune_ovr", working_output_out, 16'h0300);
    chk("out_hi", working_limits_out.hi, 16'h0300);
    i_lpoc_pid.tune <= 1'b0;
    i_lpoc_pid.lim <= {16'sh1388, 16'shEC78};
    wr(OFS_OUT_HI, 16'h2710);
    tk();
    chk("set_hi", working_limits_out.hi, 16'h1388);
    chk("set_lo", working_limits_out.lo, 16'hEC78);
    wr(OFS_SCHED_HI, 16'h0FA0);
    wr(OFS_SCHED_LO, 16'hF830);
    wr(OFS_CTRL, 16'h0008);
    tk();
    chk("sched_hi", working_limits_out.hi, 16'h0FA0);
    chk("sched_lo", working_limits_out.lo, 16'hF830);
    i_lpoc_pid.rem <= {16'sh07D0, 16'shFC18};
    i_lpoc_pid.con <= 1'b1;
    // Remote limits are latched on one tick and take part on the next.
    tk();
    tk();
    chk("rem_hi", working_limits_out.hi, 16'h07D0);
    chk("rem_lo", working_limits_out.lo, 16'hFC18);
    repeat (18) tk();
    i_lpoc_pid.dem <= 16'sh0000;
    tk();
    chk("sb_pre", working_output_out, 16'h03E8);
    wr(OFS_RATE, 16'h2710);
    wr(OFS_CTRL, 16'h000A);
    i_lpoc_pid.sb <= 1'b1;
    tk();
    chk("sb_hold_rate", working_output_out, 16'h04B0);
    finish_test();
  end

endmodule : lpoc_top_tb

bind lpoc_top lpoc_top_properties #(.TICK_LEN(TICK_LEN)) i_lpoc_top_properties (
  .mclk_in(mclk_in), .reset_in(reset_in), .rd_in(rd_in),
  .rd_data_out(rd_data_out), .feedforward_value_in(feedforward_value_in),
  .working_output_out(working_output_out),
  .working_limits_out(working_limits_out),
  .pid_feedback_out(pid_feedback_out), .pid_auto_out(pid_auto_out),
  .pid_track_out(pid_track_out), .tick_out(tick_out));
